// *** pcl_pkg.sv ***
// Constants shared by the port configuration word loader and its register banks
package pcl_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int PORT_NUM = 6; // Ports in the switch
  localparam int PORT_IDX_W = 3; // Width of a port index
  localparam int WORD_W = 16; // Width of a stored configuration word
  localparam int TADDR_W = 9; // Width of a table byte address
  localparam int CFG_OFF_W = 12; // Width of a configuration offset
  localparam int DATA_W = 32; // Width of a configuration register
  ////////////////////////////////////////////////////////////////////////////////
  // Table addresses of the words
  localparam logic [TADDR_W-1:0] TA_ACK_FIRST = 9'h0E6; // Latency word of first loaded port
  localparam logic [TADDR_W-1:0] TA_PHY_P0 = 9'h0F0; // Physical control word of port 0
  localparam logic [TADDR_W-1:0] TA_VC1_P0 = 9'h100; // VC1 word of port 0
  localparam logic [TADDR_W-1:0] TA_STRIDE = 9'h002; // Words sit two bytes apart
  localparam int ACK_FIRST_PORT = 3; // First port with a latency word
  localparam int PM_FIRST_PORT = 1; // First port with a power management bit
  localparam int VC1_PORT = 0; // Only port whose VC1 word is handled here
  ////////////////////////////////////////////////////////////////////////////////
  // Configuration offsets
  localparam logic [CFG_OFF_W-1:0] OFF_ACK_LATENCY_CONTROL = 12'h070;
  localparam logic [CFG_OFF_W-1:0] OFF_PHY_PORT_CONTROL = 12'h08C;
  localparam logic [CFG_OFF_W-1:0] OFF_VENDOR_PM_CAPABILITY = 12'h09C;
  localparam logic [CFG_OFF_W-1:0] OFF_VC1_RESOURCE_CAPABILITY = 12'h15C;
  localparam logic [CFG_OFF_W-1:0] OFF_VC1_RESOURCE_CONTROL = 12'h160;
  ////////////////////////////////////////////////////////////////////////////////
  // Field widths
  localparam int ACK_VAL_W = 14;
  localparam int PHY_BYTE_W = 8;
  localparam int VC1_SLOT_W = 7;
  localparam int TC_MAP_W = 8;
  // Field positions inside the configuration registers
  localparam int REG_ACK_VAL_LSB = 16;
  localparam int REG_ACK_EN_BIT = 30;
  localparam int REG_PHY_BYTE_LSB = 16;
  localparam int REG_DIS_BIT = 10;
  localparam int REG_RSEL_BIT = 11;
  localparam int REG_PM_BIT = 0;
  localparam int REG_VC1_SLOT_LSB = 16;
  localparam int REG_TC_MAP_LSB = 0;
  // Field positions inside the stored words
  localparam int WRD_ACK_VAL_LSB = 0;
  localparam int WRD_ACK_EN_BIT = 14;
  localparam int WRD_PHY_BYTE_LSB = 0;
  localparam int WRD_DIS_BIT = 12;
  localparam int WRD_PM_BIT = 13;
  localparam int WRD_RSEL_BIT = 14;
  localparam int WRD_VC1_SLOT_LSB = 0;
  localparam int WRD_TC_MAP_LSB = 8;
  ////////////////////////////////////////////////////////////////////////////////
  // Register defaults before any word is loaded
  localparam logic [ACK_VAL_W-1:0] RST_ACK_VAL = 14'h0000;
  localparam logic RST_ACK_EN = 1'b0;
  localparam logic [PHY_BYTE_W-1:0] RST_PHY_BYTE = 8'h00;
  localparam logic RST_DIS = 1'b0;
  localparam logic RST_RSEL = 1'b0;
  localparam logic RST_PM = 1'b0;
  localparam logic [VC1_SLOT_W-1:0] RST_VC1_SLOT = 7'h00;
  localparam logic [TC_MAP_W-1:0] RST_TC_MAP = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // Loader states, one-hot
  typedef enum logic [1:0]
  {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } pcl_state_t;
endpackage : pcl_pkg

// *** pcl_port_bank.sv ***
// Configuration fields of one switch port, filled by the loader or by config writes
`timescale 1ns/100ps
module pcl_port_bank
  import pcl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ld_ack,
  input wire logic ld_phy,
  input wire logic ld_pm,
  input wire logic ld_vc1,
  input wire logic [ACK_VAL_W-1:0] w_ack_val,
  input wire logic w_ack_en,
  input wire logic [PHY_BYTE_W-1:0] w_phy_byte,
  input wire logic w_dis,
  input wire logic w_rsel,
  input wire logic w_pm,
  input wire logic [VC1_SLOT_W-1:0] w_vc1_slot,
  input wire logic [TC_MAP_W-1:0] w_tc_map,
  input wire logic wr_en,
  input wire logic [CFG_OFF_W-1:0] wr_off,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [ACK_VAL_W-1:0] ack_val,
  output logic ack_en,
  output logic [PHY_BYTE_W-1:0] phy_byte,
  output logic dis,
  output logic rsel,
  output logic pm,
  output logic [VC1_SLOT_W-1:0] vc1_slot,
  output logic [TC_MAP_W-1:0] tc_map
);
  ////////////////////////////////////////////////////////////////////////////////
  // Write decode per register
  wire logic wr_ack = wr_en && (wr_off == OFF_ACK_LATENCY_CONTROL); // Latency register
  wire logic wr_phy = wr_en && (wr_off == OFF_PHY_PORT_CONTROL); // Physical control register
  wire logic wr_pm = wr_en && (wr_off == OFF_VENDOR_PM_CAPABILITY); // PM capability register
  wire logic wr_cap = wr_en && (wr_off == OFF_VC1_RESOURCE_CAPABILITY); // VC1 capability
  wire logic wr_ctl = wr_en && (wr_off == OFF_VC1_RESOURCE_CONTROL); // VC1 control

  ////////////////////////////////////////////////////////////////////////////////
  // Latency value and its enable; a loaded word beats a write in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_val <= RST_ACK_VAL;
      ack_en <= RST_ACK_EN;
    end
    else if (ld_ack)
    begin
      ack_val <= w_ack_val;
      ack_en <= w_ack_en;
    end
    else if (wr_ack)
    begin
      ack_val <= wr_data[REG_ACK_VAL_LSB +: ACK_VAL_W];
      ack_en <= wr_data[REG_ACK_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Physical control byte, port disable and reset select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phy_byte <= RST_PHY_BYTE;
      dis <= RST_DIS;
      rsel <= RST_RSEL;
    end
    else if (ld_phy)
    begin
      phy_byte <= w_phy_byte;
      dis <= w_dis;
      rsel <= w_rsel;
    end
    else if (wr_phy)
    begin
      phy_byte <= wr_data[REG_PHY_BYTE_LSB +: PHY_BYTE_W];
      dis <= wr_data[REG_DIS_BIT];
      rsel <= wr_data[REG_RSEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Device specific power management bit
  always_ff @(posedge clk)
  begin
    if (rst)
      pm <= RST_PM;
    else if (ld_pm)
      pm <= w_pm;
    else if (wr_pm)
      pm <= wr_data[REG_PM_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // VC1 time slot count and traffic class map
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vc1_slot <= RST_VC1_SLOT;
      tc_map <= RST_TC_MAP;
    end
    else
    begin
      if (ld_vc1)
        vc1_slot <= w_vc1_slot;
      else if (wr_cap)
        vc1_slot <= wr_data[REG_VC1_SLOT_LSB +: VC1_SLOT_W];
      if (ld_vc1)
        tc_map <= w_tc_map;
      else if (wr_ctl)
        tc_map <= wr_data[REG_TC_MAP_LSB +: TC_MAP_W];
    end
  end
endmodule : pcl_port_bank

// *** pcl_word_loader.sv ***
// Top of the port configuration word loader: word decode, banks, config access
//
// What this block does
// - Word E6h bits 13:0 to port 3 latency
// - Latency word bit 14 sets user latency enable
// - Ports 4 and 5 latency from E8h, EAh
// - Words F0h-FAh bits 7:0 to control byte
// - Per-port word bit 12 gives port disable
// - Per-port word bit 14 gives reset select
// - Ports 1-5 word bit 13 gives PM bit
// - Word 100h bits 6:0 to VC1 slots
// - Word 100h bits 15:8 to TC map
`timescale 1ns/100ps
module pcl_word_loader
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic LD_WORD_VALID,
  input wire logic [pcl_pkg::TADDR_W-1:0] LD_WORD_ADDR,
  input wire logic [pcl_pkg::WORD_W-1:0] LD_WORD_DATA,
  input wire logic LD_DONE,
  input wire logic CFG_REQ,
  input wire logic CFG_WE,
  input wire logic [pcl_pkg::PORT_IDX_W-1:0] CFG_PORT,
  input wire logic [pcl_pkg::CFG_OFF_W-1:0] CFG_OFFSET,
  input wire logic [pcl_pkg::DATA_W-1:0] CFG_WDATA,
  output logic CFG_READY,
  output logic CFG_ACK,
  output logic [pcl_pkg::DATA_W-1:0] CFG_RDATA,
  output logic [pcl_pkg::PORT_NUM-1:0] PORT_DISABLE
);
  import pcl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Table hit for the word of a given index past a base address
  function automatic logic word_hit(input logic [TADDR_W-1:0] addr,
                                    input logic [TADDR_W-1:0] base,
                                    input int idx);
    logic [TADDR_W-1:0] target;
    target = TADDR_W'(base + TADDR_W'(idx) * TA_STRIDE);
    return addr == target;
  endfunction : word_hit

  ////////////////////////////////////////////////////////////////////////////////
  // Fields cut from the incoming word, shared by every bank
  wire logic [ACK_VAL_W-1:0] word_ack_val = LD_WORD_DATA[WRD_ACK_VAL_LSB +: ACK_VAL_W];
  wire logic word_ack_en = LD_WORD_DATA[WRD_ACK_EN_BIT];
  wire logic [PHY_BYTE_W-1:0] word_phy_byte = LD_WORD_DATA[WRD_PHY_BYTE_LSB +: PHY_BYTE_W];
  wire logic word_dis = LD_WORD_DATA[WRD_DIS_BIT];
  wire logic word_rsel = LD_WORD_DATA[WRD_RSEL_BIT];
  wire logic word_pm = LD_WORD_DATA[WRD_PM_BIT];
  wire logic [VC1_SLOT_W-1:0] word_vc1_slot = LD_WORD_DATA[WRD_VC1_SLOT_LSB +: VC1_SLOT_W];
  wire logic [TC_MAP_W-1:0] word_tc_map = LD_WORD_DATA[WRD_TC_MAP_LSB +: TC_MAP_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Loader state; config access is held off from reset until the store signals done
  pcl_state_t state; // Current state
  pcl_state_t next_state; // Value for the next edge

  assign next_state = (state == ST_LOAD && LD_DONE) ? ST_RUN : state;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      state <= ST_LOAD;
    else
      state <= next_state;
  end

  // Only the run state opens the config port
  always_comb
  begin
    case (state)
      ST_LOAD: CFG_READY = 1'b0;
      ST_RUN: CFG_READY = 1'b1;
      default: CFG_READY = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Config request decode
  wire logic take = CFG_REQ && CFG_READY; // Requests in the load state after reset are dropped
  wire logic port_ok = CFG_PORT < PORT_IDX_W'(PORT_NUM); // Nonexistent ports read zero
  wire logic [PORT_IDX_W-1:0] sel = port_ok ? CFG_PORT : '0; // Safe array index

  // Per-port field arrays
  logic [ACK_VAL_W-1:0] ack_val [PORT_NUM];
  logic ack_en [PORT_NUM];
  logic [PHY_BYTE_W-1:0] phy_byte [PORT_NUM];
  logic dis [PORT_NUM];
  logic rsel [PORT_NUM];
  logic pm [PORT_NUM];
  logic [VC1_SLOT_W-1:0] vc1_slot [PORT_NUM];
  logic [TC_MAP_W-1:0] tc_map [PORT_NUM];
  logic [PORT_NUM-1:0] ld_ack; // Latency word hit per port
  logic [PORT_NUM-1:0] ld_phy; // Control word hit per port
  logic [PORT_NUM-1:0] ld_pm; // PM bit load per port
  logic [PORT_NUM-1:0] ld_vc1; // VC1 word hit per port

  ////////////////////////////////////////////////////////////////////////////////
  // One bank per port; which words reach it depends on the port number
  for (genvar p = 0; p < PORT_NUM; p++)
  begin : g_port
    if (p >= ACK_FIRST_PORT)
    begin : g_ack
      assign ld_ack[p] = LD_WORD_VALID &&
                         word_hit(LD_WORD_ADDR, TA_ACK_FIRST, p - ACK_FIRST_PORT);
    end
    else
    begin : g_no_ack
      assign ld_ack[p] = 1'b0;
    end
    assign ld_phy[p] = LD_WORD_VALID && word_hit(LD_WORD_ADDR, TA_PHY_P0, p);
    // Port 0 has no PM field in its word, so its bit keeps its default
    assign ld_pm[p] = (p >= PM_FIRST_PORT) && ld_phy[p];
    assign ld_vc1[p] = (p == VC1_PORT) && LD_WORD_VALID &&
                       word_hit(LD_WORD_ADDR, TA_VC1_P0, 0);
    assign PORT_DISABLE[p] = dis[p];

    pcl_port_bank u_bank
    (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .ld_ack(ld_ack[p]),
      .ld_phy(ld_phy[p]),
      .ld_pm(ld_pm[p]),
      .ld_vc1(ld_vc1[p]),
      .w_ack_val(word_ack_val),
      .w_ack_en(word_ack_en),
      .w_phy_byte(word_phy_byte),
      .w_dis(word_dis),
      .w_rsel(word_rsel),
      .w_pm(word_pm),
      .w_vc1_slot(word_vc1_slot),
      .w_tc_map(word_tc_map),
      .wr_en(take && CFG_WE && port_ok && (CFG_PORT == PORT_IDX_W'(p))),
      .wr_off(CFG_OFFSET),
      .wr_data(CFG_WDATA),
      .ack_val(ack_val[p]),
      .ack_en(ack_en[p]),
      .phy_byte(phy_byte[p]),
      .dis(dis[p]),
      .rsel(rsel[p]),
      .pm(pm[p]),
      .vc1_slot(vc1_slot[p]),
      .tc_map(tc_map[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read word assembly; unlisted bits and unmapped offsets read zero
  wire logic [DATA_W-1:0] rd_ack = (DATA_W'(ack_val[sel]) << REG_ACK_VAL_LSB) |
                                   (DATA_W'(ack_en[sel]) << REG_ACK_EN_BIT);
  wire logic [DATA_W-1:0] rd_phy = (DATA_W'(phy_byte[sel]) << REG_PHY_BYTE_LSB) |
                                   (DATA_W'(dis[sel]) << REG_DIS_BIT) |
                                   (DATA_W'(rsel[sel]) << REG_RSEL_BIT);
  wire logic [DATA_W-1:0] rd_pm = DATA_W'(pm[sel]) << REG_PM_BIT;
  wire logic [DATA_W-1:0] rd_cap = DATA_W'(vc1_slot[sel]) << REG_VC1_SLOT_LSB;
  wire logic [DATA_W-1:0] rd_ctl = DATA_W'(tc_map[sel]) << REG_TC_MAP_LSB;
  wire logic [DATA_W-1:0] rd_sel =
    !port_ok ? '0 :
    (CFG_OFFSET == OFF_ACK_LATENCY_CONTROL) ? rd_ack :
    (CFG_OFFSET == OFF_PHY_PORT_CONTROL) ? rd_phy :
    (CFG_OFFSET == OFF_VENDOR_PM_CAPABILITY) ? rd_pm :
    (CFG_OFFSET == OFF_VC1_RESOURCE_CAPABILITY) ? rd_cap :
    (CFG_OFFSET == OFF_VC1_RESOURCE_CONTROL) ? rd_ctl : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Answer one cycle after a taken request; data holds until the next read answer
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      CFG_ACK <= 1'b0;
    else
      CFG_ACK <= take;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      CFG_RDATA <= '0;
    else if (take && !CFG_WE)
      CFG_RDATA <= rd_sel;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_word(logic [TADDR_W-1:0] a);
    LD_WORD_VALID && LD_WORD_ADDR == a;
  endsequence
  sequence s_rd_ack3;
    take && !CFG_WE && CFG_PORT == 3'h3 && CFG_OFFSET == OFF_ACK_LATENCY_CONTROL;
  endsequence

  property p_ack_p3;
    s_word(9'h0E6) |=> ack_val[3] == $past(word_ack_val);
  endproperty
  a_ack_p3: assert property (p_ack_p3) else $error("port 3 latency not loaded");
  property p_ack_en;
    s_word(9'h0E6) |=> ack_en[3] == $past(word_ack_en) ##1 1'b1;
  endproperty
  a_ack_en: assert property (p_ack_en) else $error("latency enable not loaded");
  // Each latency word must reach its own port, not just either of the two
  property p_ack_p45;
    (s_word(9'h0E8) |=> ack_val[4] == $past(word_ack_val)) and
    (s_word(9'h0EA) |=> ack_val[5] == $past(word_ack_val));
  endproperty
  a_ack_p45: assert property (p_ack_p45) else $error("port 4/5 latency not loaded");
  property p_phy_p3;
    s_word(9'h0F6) |=> phy_byte[3] == $past(word_phy_byte) && $stable(phy_byte[2]);
  endproperty
  a_phy_p3: assert property (p_phy_p3) else $error("control byte misplaced");
  property p_dis_p0;
    s_word(9'h0F0) |=> PORT_DISABLE[0] == $past(word_dis);
  endproperty
  a_dis_p0: assert property (p_dis_p0) else $error("port disable not loaded");
  property p_rsel_p5;
    s_word(9'h0FA) |=> rsel[5] == $past(word_rsel);
  endproperty
  a_rsel_p5: assert property (p_rsel_p5) else $error("reset select not loaded");
  property p_pm;
    s_word(9'h0F2) |=> pm[1] == $past(word_pm);
  endproperty
  a_pm: assert property (p_pm) else $error("PM bit not loaded");
  property p_pm_p0;
    s_word(9'h0F0) |=> $stable(pm[0]);
  endproperty
  a_pm_p0: assert property (p_pm_p0) else $error("port 0 PM bit changed by load");
  property p_vc1_slot;
    s_word(9'h100) |=> vc1_slot[0] == $past(word_vc1_slot);
  endproperty
  a_vc1_slot: assert property (p_vc1_slot) else $error("VC1 slots not loaded");
  property p_tc_map;
    s_word(9'h100) |=> tc_map[0] == $past(word_tc_map);
  endproperty
  a_tc_map: assert property (p_tc_map) else $error("TC map not loaded");
  property p_hold_off;
    (state == ST_LOAD) && CFG_REQ |=> !CFG_ACK;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("access answered while loading");
  property p_rd_ack3;
    s_rd_ack3 |=> CFG_ACK && CFG_RDATA[REG_ACK_VAL_LSB +: ACK_VAL_W] == ack_val[3];
  endproperty
  a_rd_ack3: assert property (p_rd_ack3) else $error("latency read wrong");
endmodule : pcl_word_loader

// *** pcl_store_model.sv ***
// Behavioural model of the non-volatile store that streams configuration words
`timescale 1ns/100ps
module pcl_store_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] gap,
  input wire logic [15:0] words [12],
  output logic valid,
  output logic [8:0] addr,
  output logic [15:0] data,
  output logic done
);
  ////////////////////////////////////////////////////////////////////////////////
  // Word addresses; the last two are not loaded and must be ignored
  localparam logic [8:0] ADDRS [12] = '{9'h0E6, 9'h0E8, 9'h0EA, 9'h0F0, 9'h0F2, 9'h0F4,
    9'h0F6, 9'h0F8, 9'h0FA, 9'h100, 9'h0E0, 9'h102};
  int idx; // Next word to send
  int wait_cnt; // Idle cycles left before next word
  logic busy; // Streaming in progress
  ////////////////////////////////////////////////////////////////////////////////
  // Known idle levels before the first reset edge
  initial
  begin
    valid = 1'b0;
    done = 1'b0;
    addr = 9'h000;
    data = 16'h0000;
    busy = 1'b0;
    idx = 0;
    wait_cnt = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Streamer; a released bus toggles so stale data never looks valid
  always @(posedge clk)
  begin
    done <= 1'b0;
    valid <= 1'b0;
    addr <= ~addr;
    data <= ~data;
    if (rst)
    begin
      busy <= 1'b0;
      idx <= 0;
      wait_cnt <= 0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      idx <= 0;
      wait_cnt <= 0;
    end
    else if (busy)
    begin
      // Slow store: gap idle cycles between words
      if (wait_cnt != 0)
        wait_cnt <= wait_cnt - 1;
      else if (idx == 12)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else
      begin
        valid <= 1'b1;
        addr <= ADDRS[idx];
        data <= words[idx];
        idx <= idx + 1;
        wait_cnt <= int'(gap);
      end
    end
  end
endmodule : pcl_store_model

// *** tb.sv ***
// Self-checking testbench of the port configuration word loader
`timescale 1ns/100ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error %0t: mismatch got %h expected %h", $time, got, exp); end end
module tb;
  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CFG_REQ = 1'b0;
  logic CFG_WE = 1'b0;
  logic [2:0] CFG_PORT = 3'h0;
  logic [11:0] CFG_OFFSET = 12'h000;
  logic [31:0] CFG_WDATA = 32'h0000_0000;
  logic CFG_READY, CFG_ACK, LD_WORD_VALID, LD_DONE;
  logic [31:0] CFG_RDATA;
  logic [5:0] PORT_DISABLE;
  logic [8:0] LD_WORD_ADDR;
  logic [15:0] LD_WORD_DATA;
  logic st = 1'b0; // Store start pulse
  logic [3:0] gap = 4'h0; // Store pacing
  logic [15:0] cur [12] = '{16'h7A5C, 16'h4123, 16'h3FFF, 16'h7A81, 16'h2B42, 16'h7004,
    16'h1FC8, 16'h6E10, 16'h3320, 16'hC37F, 16'hFFFF, 16'hFFFF};
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] d; // Read data
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, store and design
  always #12.5 REF_CLK = ~REF_CLK;
  pcl_store_model store (.clk(REF_CLK), .rst(SYS_RST), .start(st), .gap(gap), .words(cur),
    .valid(LD_WORD_VALID), .addr(LD_WORD_ADDR), .data(LD_WORD_DATA), .done(LD_DONE));
  pcl_word_loader dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .LD_WORD_VALID(LD_WORD_VALID),
    .LD_WORD_ADDR(LD_WORD_ADDR), .LD_WORD_DATA(LD_WORD_DATA), .LD_DONE(LD_DONE),
    .CFG_REQ(CFG_REQ), .CFG_WE(CFG_WE), .CFG_PORT(CFG_PORT), .CFG_OFFSET(CFG_OFFSET),
    .CFG_WDATA(CFG_WDATA), .CFG_READY(CFG_READY), .CFG_ACK(CFG_ACK), .CFG_RDATA(CFG_RDATA),
    .PORT_DISABLE(PORT_DISABLE));
  ////////////////////////////////////////////////////////////////////////////////
  // Expected register image from the current word set; unloaded fields read zero
  function automatic logic [31:0] exp_reg(input int p, input logic [11:0] off);
    logic [15:0] w;
    w = (p <= 5) ? cur[3 + p] : 16'h0000;
    exp_reg = 32'h0000_0000;
    if (off == 12'h070 && p >= 3 && p <= 5)
      exp_reg = {1'b0, cur[p - 3][14], cur[p - 3][13:0], 16'h0000};
    else if (off == 12'h08C && p <= 5)
      exp_reg = {8'h00, w[7:0], 4'h0, w[14], w[12], 10'h000};
    else if (off == 12'h09C && p >= 1 && p <= 5)
      exp_reg = {31'h0000_0000, w[13]};
    else if (off == 12'h15C && p == 0)
      exp_reg = {9'h000, cur[9][6:0], 16'h0000};
    else if (off == 12'h160 && p == 0)
      exp_reg = {24'h00_0000, cur[9][15:8]};
  endfunction : exp_reg
  ////////////////////////////////////////////////////////////////////////////////
  // One config access; the answer is seen just after the edge that takes the request
  task automatic cfg_access(input logic we, input int p, input logic [11:0] off,
                            input logic [31:0] wd, output logic [31:0] rd);
    @(posedge REF_CLK);
    CFG_REQ <= 1'b1;
    CFG_WE <= we;
    CFG_PORT <= 3'(p);
    CFG_OFFSET <= off;
    CFG_WDATA <= wd;
    @(posedge REF_CLK);
    CFG_REQ <= 1'b0;
    #1;
    `CHECK(CFG_ACK, 1'b1)
    rd = CFG_RDATA;
  endtask : cfg_access
  // Request after reset, before loading is finished, must never be answered
  task automatic refused_req();
    @(posedge REF_CLK);
    CFG_REQ <= 1'b1;
    CFG_WE <= 1'b0;
    @(posedge REF_CLK);
    CFG_REQ <= 1'b0;
    repeat (3)
    begin
      #1;
      `CHECK({CFG_ACK, CFG_READY}, 2'b00)
      @(posedge REF_CLK);
    end
  endtask : refused_req
  // Start the store, wait for its done pulse, config access opens next edge
  task automatic load_all(input logic [3:0] g);
    int n;
    n = 0;
    @(posedge REF_CLK);
    st <= 1'b1;
    gap <= g;
    @(posedge REF_CLK);
    st <= 1'b0;
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (LD_DONE !== 1'b1 && n < 300);
    #1;
    `CHECK(n < 300, 1'b1)
    `CHECK(CFG_READY, 1'b1)
  endtask : load_all
  // Read every field of every port, plus an unmapped offset
  task automatic check_all();
    for (int p = 0; p < 8; p++)
    begin
      cfg_access(1'b0, p, 12'h070, 32'h0000_0000, d);
      `CHECK(d, exp_reg(p, 12'h070))
      cfg_access(1'b0, p, 12'h08C, 32'h0000_0000, d);
      `CHECK(d, exp_reg(p, 12'h08C))
      cfg_access(1'b0, p, 12'h09C, 32'h0000_0000, d);
      `CHECK(d, exp_reg(p, 12'h09C))
      cfg_access(1'b0, p, 12'h15C, 32'h0000_0000, d);
      `CHECK(d, exp_reg(p, 12'h15C))
      cfg_access(1'b0, p, 12'h160, 32'h0000_0000, d);
      `CHECK(d, exp_reg(p, 12'h160))
      cfg_access(1'b0, p, 12'h074, 32'h0000_0000, d);
      `CHECK(d, 32'h0000_0000)
    end
    `CHECK(PORT_DISABLE, {cur[8][12], cur[7][12], cur[6][12],
      cur[5][12], cur[4][12], cur[3][12]})
  endtask : check_all
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the sequence or the watchdog
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    bad_count++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    #1;
    `CHECK(PORT_DISABLE, 6'h00)
    refused_req();
    load_all(4'h0);
    check_all();
    // Writes: only field bits stick, unmapped places ignored
    cfg_access(1'b1, 2, 12'h08C, 32'hFFFF_FFFF, d);
    cfg_access(1'b0, 2, 12'h08C, 32'h0000_0000, d);
    `CHECK(d, 32'h00FF_0C00)
    `CHECK(PORT_DISABLE[2], 1'b1)
    cfg_access(1'b1, 1, 12'h15C, 32'hFFFF_FFFF, d);
    cfg_access(1'b0, 1, 12'h15C, 32'h0000_0000, d);
    `CHECK(d, 32'h007F_0000)
    // Port 1 VC1 storage is never reloaded, so put its default back
    cfg_access(1'b1, 1, 12'h15C, 32'h0000_0000, d);
    cfg_access(1'b1, 4, 12'h070, 32'hFFFF_FFFF, d);
    cfg_access(1'b0, 4, 12'h070, 32'h0000_0000, d);
    `CHECK(d, 32'h7FFF_0000)
    cfg_access(1'b1, 3, 12'h09C, 32'hFFFF_FFFF, d);
    cfg_access(1'b0, 3, 12'h09C, 32'h0000_0000, d);
    `CHECK(d, 32'h0000_0001)
    cfg_access(1'b1, 0, 12'h160, 32'hFFFF_FFFF, d);
    cfg_access(1'b0, 0, 12'h160, 32'h0000_0000, d);
    `CHECK(d, 32'h0000_00FF)
    cfg_access(1'b1, 6, 12'h08C, 32'hFFFF_FFFF, d);
    cfg_access(1'b1, 0, 12'h074, 32'hFFFF_FFFF, d);
    // Reload a complementary set from a slow store
    foreach (cur[i]) cur[i] = ~cur[i];
    load_all(4'h3);
    check_all();
    // Reset in mid-run clears writes and closes access until reload
    @(posedge REF_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    #1;
    `CHECK(PORT_DISABLE, 6'h00)
    refused_req();
    load_all(4'h1);
    check_all();
    final_report();
  end
endmodule : tb
